// ### buck_timing_status_cfg.svh
// offsets, field positions, reset values and timing counts for the rail register bank
`ifndef BUCK_TIMING_STATUS_CFG_SVH
`define BUCK_TIMING_STATUS_CFG_SVH

// register offsets on the register port
`define TIMING_CFG_ADDR 8'h47
`define STATUS_MASK_ADDR 8'h60

// reset values
`define TIMING_CFG_RST 8'hC0
`define STATUS_MASK_RST 4'hF

// timing register fields
`define PH_DELAY_BIT 7
`define PH_EDGE_BIT 6
`define ON_DLY_MSB 5
`define ON_DLY_LSB 3
`define OFF_DLY_MSB 2
`define OFF_DLY_LSB 0

// status/mask register fields
`define POK_BIT 7
`define HIGH_OUT_BIT 6
`define CURRENT_LIMIT_FLAG_BIT 5
`define UV_MASK_BIT 3
`define HIGH_OUT_MASK_BIT 2
`define CURRENT_LIMIT_FLAG_MASK_BIT 1

// timing
`define CLK_MHZ 125
`define PHASE_DELAY_NS 100
`define PHASE_DELAY_CYC ((`PHASE_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define SEQ_TICK_NS 500000
`define SEQ_TICK_CYC ((`SEQ_TICK_NS * `CLK_MHZ) / 1000)
`define CURRENT_LIMIT_FLAG_RUN_CYCLES 16

`endif

// ### buck_timing_status_pkg.sv
// types shared by the rail register bank
package buck_timing_status_pkg;
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_COUNT = 1'b1
    } seq_state_t;
endpackage : buck_timing_status_pkg

// ### seq_delay_timer.sv
// turn-on / turn-off sequencing delay timer for rail 1
`include "buck_timing_status_cfg.svh"

module seq_delay_timer #(
    parameter int TICK_CYCLES = `SEQ_TICK_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // synchronised enable and delay codes
    input wire logic en_in,
    input wire logic [2:0] on_code,
    input wire logic [2:0] off_code,
    // resulting rail state
    output logic rail_on,
    output buck_timing_status_pkg::seq_state_t state
);
    import buck_timing_status_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LOAD = PW'(TICK_CYCLES - 1);

    logic en_prev_r, target_r, rail_on_r;
    logic [PW-1:0] pre_r;
    logic [6:0] units_r;
    seq_state_t state_r;

    // any change of the input restarts the wait from scratch
    wire edge_seen = en_in ^ en_prev_r;
    wire [2:0] code = en_in ? on_code : off_code;
    wire [6:0] units = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
    wire tick = (state_r == SEQ_COUNT) && (pre_r == {PW{1'b0}});

    // 0.5 ms prescaler and unit counter
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            en_prev_r <= 1'b0;
            target_r <= 1'b0;
            rail_on_r <= 1'b0;
            pre_r <= {PW{1'b0}};
            units_r <= 7'h00;
            state_r <= SEQ_IDLE;
        end else begin
            en_prev_r <= en_in;
            if (edge_seen) begin
                target_r <= en_in;
                units_r <= units;
                pre_r <= PRE_LOAD;
                if (units == 7'h00) begin
                    rail_on_r <= en_in;
                    state_r <= SEQ_IDLE;
                end else begin
                    state_r <= SEQ_COUNT;
                end
            end else begin
                unique case (state_r)
                    SEQ_IDLE: begin
                        pre_r <= pre_r;
                    end
                    SEQ_COUNT: begin
                        pre_r <= tick ? PRE_LOAD : pre_r - PW'(1);
                        if (tick && units_r == 7'h01) begin
                            rail_on_r <= target_r;
                            state_r <= SEQ_IDLE;
                        end else if (tick) begin
                            units_r <= units_r - 7'h01;
                        end
                    end
                endcase
            end
        end
    end

    assign rail_on = rail_on_r;
    assign state = state_r;

    a_seq_zero_now: assert property (@(posedge core_clk) disable iff (!resetn)
        edge_seen && units == 7'h00 |=> rail_on_r == $past(en_in))
        else $error("zero-code edge did not act at once");
    a_seq_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        state_r == SEQ_COUNT && !tick && !edge_seen |=> $stable(rail_on_r))
        else $error("rail changed before delay expiry");
    c_seq_delayed: cover property (@(posedge core_clk) disable iff (!resetn)
        tick && units_r == 7'h01 && !edge_seen);
endmodule : seq_delay_timer

// ### buck_timing_status_regs.sv
// rail 1 timing configuration and rail 2 status/mask register logic
// How it works
// - phase bit 1 delays switching 100ns
// - edge bit picks rising or falling reference
// - bits 5:3 set turn-on delay
// - bits 2:0 set turn-off delay
// - timing register resets C0, read-write
// - status resets 0F, flags read-only, masks writable
// - high-output flag holds until drop and read
// - current limit after 16 cycles, sticky
// - mask bits 3:1 block faults, bit 0 blocks nothing, status stays live
`include "buck_timing_status_cfg.svh"

module buck_timing_status_regs #(
    parameter int SEQ_TICK_CYCLES = `SEQ_TICK_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // pins from converters and clock reference
    input wire logic main_clk_ref,
    input wire logic rail1_enable,
    input wire logic rail2_power_good_raw,
    input wire logic rail2_high_output_raw,
    input wire logic rail2_peak_at_limit_raw,
    // converter control
    output logic rail1_switch_pulse,
    output logic rail1_turn_on,
    output buck_timing_status_pkg::seq_state_t rail1_seq_state,
    // fault outputs toward the master fault logic
    output logic rail2_undervolt_fault,
    output logic rail2_high_output_fault,
    output logic rail2_current_limit_fault
);
    import buck_timing_status_pkg::*;

    localparam int NS = 5;
    localparam logic [4:0] PH_LOAD = 5'(`PHASE_DELAY_CYC);
    localparam logic [4:0] CURRENT_LIMIT_FLAG_RUN = 5'(`CURRENT_LIMIT_FLAG_RUN_CYCLES);

    // two-flop synchronisers for all pins
    logic [NS-1:0] sync1_r, sync2_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync1_r <= {NS{1'b0}};
            sync2_r <= {NS{1'b0}};
        end else begin
            sync1_r <= {rail2_peak_at_limit_raw, rail2_high_output_raw,
                        rail2_power_good_raw, rail1_enable, main_clk_ref};
            sync2_r <= sync1_r;
        end
    end
    wire ref_s = sync2_r[0];
    wire en_s = sync2_r[1];
    wire pok_s = sync2_r[2];
    wire ov_s = sync2_r[3];
    wire peak_s = sync2_r[4];

    // register decode
    logic [7:0] timing_r;
    logic [3:0] mask_r;
    wire sel_timing = reg_addr == `TIMING_CFG_ADDR;
    wire sel_status = reg_addr == `STATUS_MASK_ADDR;
    wire status_read = reg_rd_en && sel_status;
    logic [1:0] flag_r;

    wire [7:0] status_word = {pok_s, flag_r[0], flag_r[1], 1'b0, mask_r};
    wire [7:0] rd_word = sel_timing ? timing_r : (sel_status ? status_word : 8'h00);

    // writable bits; flags above bit 3 ignore writes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            timing_r <= `TIMING_CFG_RST;
            mask_r <= `STATUS_MASK_RST;
            reg_rd_data <= 8'h00;
        end else begin
            if (reg_wr_en && sel_timing) timing_r <= reg_wr_data;
            if (reg_wr_en && sel_status) mask_r <= reg_wr_data[3:0];
            if (reg_rd_en) reg_rd_data <= rd_word;
        end
    end

    // switching phase: pick reference edge, optionally delay it
    logic ref_prev_r, sw_pulse_r;
    logic [4:0] ph_cnt_r;
    wire ref_rise = ref_s & ~ref_prev_r;
    wire ref_fall = ~ref_s & ref_prev_r;
    wire sel_edge = timing_r[`PH_EDGE_BIT] ? ref_fall : ref_rise;
    wire ph_delay = timing_r[`PH_DELAY_BIT];
    wire sw_pulse_nxt = ph_delay ? (ph_cnt_r == 5'h01) : sel_edge;
    // a new edge inside the 100ns window restarts it; reference is far slower
    wire [4:0] ph_cnt_nxt = (sel_edge && ph_delay) ? PH_LOAD :
                            (ph_cnt_r != 5'h00) ? ph_cnt_r - 5'h01 : 5'h00;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ref_prev_r <= 1'b0;
            ph_cnt_r <= 5'h00;
            sw_pulse_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_s;
            ph_cnt_r <= ph_cnt_nxt;
            sw_pulse_r <= sw_pulse_nxt;
        end
    end
    assign rail1_switch_pulse = sw_pulse_r;

    // run of switching cycles at the current limit
    logic [4:0] current_limit_flag_run_r;
    wire [4:0] current_limit_flag_run_nxt = !sw_pulse_r ? current_limit_flag_run_r :
                              !peak_s ? 5'h00 :
                              (current_limit_flag_run_r == CURRENT_LIMIT_FLAG_RUN) ? current_limit_flag_run_r : current_limit_flag_run_r + 5'h01;
    always_ff @(posedge core_clk) begin
        if (!resetn) current_limit_flag_run_r <= 5'h00;
        else current_limit_flag_run_r <= current_limit_flag_run_nxt;
    end
    wire current_limit_flag_cond = current_limit_flag_run_r == CURRENT_LIMIT_FLAG_RUN;

    // sticky flags: clear needs condition gone and a read since set
    wire [1:0] cond = {current_limit_flag_cond, ov_s};
    logic [1:0] seen_r;
    wire [1:0] flag_nxt;
    wire [1:0] seen_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            // a condition still present wins over a clear in the same cycle
            wire clr = ~cond[gi] & (status_read | seen_r[gi]);
            assign flag_nxt[gi] = cond[gi] | (flag_r[gi] & ~clr);
            assign seen_nxt[gi] = flag_r[gi] & flag_nxt[gi] & (seen_r[gi] | status_read);
        end
    endgenerate
    // one process owns both flag bits
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            flag_r <= 2'h0;
            seen_r <= 2'h0;
        end else begin
            flag_r <= flag_nxt;
            seen_r <= seen_nxt;
        end
    end

    // masked faults; status bits above are not gated
    logic uv_f_r, ov_f_r, il_f_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            uv_f_r <= 1'b0;
            ov_f_r <= 1'b0;
            il_f_r <= 1'b0;
        end else begin
            uv_f_r <= ~pok_s & ~mask_r[`UV_MASK_BIT];
            ov_f_r <= flag_r[0] & ~mask_r[`HIGH_OUT_MASK_BIT];
            il_f_r <= flag_r[1] & ~mask_r[`CURRENT_LIMIT_FLAG_MASK_BIT];
        end
    end
    assign rail2_undervolt_fault = uv_f_r;
    assign rail2_high_output_fault = ov_f_r;
    assign rail2_current_limit_fault = il_f_r;

    // sequencing delays
    seq_delay_timer #(
        .TICK_CYCLES(SEQ_TICK_CYCLES)
    ) u_seq (
        .core_clk(core_clk),
        .resetn(resetn),
        .en_in(en_s),
        .on_code(timing_r[`ON_DLY_MSB:`ON_DLY_LSB]),
        .off_code(timing_r[`OFF_DLY_MSB:`OFF_DLY_LSB]),
        .rail_on(rail1_turn_on),
        .state(rail1_seq_state)
    );

    // checks
    a_phase_aligned: assert property (@(posedge core_clk) disable iff (!resetn)
        sel_edge && !ph_delay |=> sw_pulse_r)
        else $error("undelayed edge gave no switch pulse");
    a_phase_delayed: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(sw_pulse_r) && ph_delay && $past(ph_delay, 14) |-> $past(sel_edge, 14))
        else $error("delayed pulse not 14 cycles after edge");
    a_cfg_write: assert property (@(posedge core_clk) disable iff (!resetn)
        reg_wr_en && sel_timing |=> timing_r == $past(reg_wr_data))
        else $error("timing register write lost");
    a_mask_write: assert property (@(posedge core_clk) disable iff (!resetn)
        reg_wr_en && sel_status |=> status_word[3:0] == $past(reg_wr_data[3:0])
        && status_word[4] == 1'b0)
        else $error("mask write wrong");
    a_ov_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        flag_r[0] && !(status_read || seen_r[0]) |=> flag_r[0])
        else $error("high-output flag cleared without read");
    a_ov_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        flag_r[0] && !ov_s && status_read |=> !flag_r[0])
        else $error("high-output flag did not clear");
    a_current_limit_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
        sw_pulse_r && peak_s && current_limit_flag_run_r == 5'h0F |=> ##1 flag_r[1])
        else $error("current limit flag not set after 16 cycles");
    a_fault_mask: assert property (@(posedge core_clk) disable iff (!resetn)
        mask_r[`HIGH_OUT_MASK_BIT] && mask_r[`CURRENT_LIMIT_FLAG_MASK_BIT]
        |=> !rail2_high_output_fault && !rail2_current_limit_fault)
        else $error("masked fault reached output");
    a_high_out_set: assert property (@(posedge core_clk) disable iff (!resetn)
        ov_s |=> flag_r[0])
        else $error("high-output flag not set");
    a_limit_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        flag_r[1] && !(status_read || seen_r[1]) |=> flag_r[1])
        else $error("current limit flag cleared without read");
    a_limit_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        flag_r[1] && !current_limit_flag_cond && (status_read || seen_r[1]) |=> !flag_r[1])
        else $error("current limit flag did not clear");
    a_undervolt_fault: assert property (@(posedge core_clk) disable iff (!resetn)
        !pok_s && !mask_r[`UV_MASK_BIT] |=> rail2_undervolt_fault)
        else $error("unmasked undervolt fault missing");
    a_timing_read: assert property (@(posedge core_clk) disable iff (!resetn)
        reg_rd_en && sel_timing |=> reg_rd_data == $past(timing_r))
        else $error("timing register read wrong");
    c_delayed_pulse: cover property (@(posedge core_clk) disable iff (!resetn)
        $rose(sw_pulse_r) && ph_delay);
    c_current_limit_flag_flag: cover property (@(posedge core_clk) disable iff (!resetn) $rose(flag_r[1]));
    c_ov_clear: cover property (@(posedge core_clk) disable iff (!resetn) $fell(flag_r[0]));
    c_rail_on: cover property (@(posedge core_clk) disable iff (!resetn) $rose(rail1_turn_on));
endmodule : buck_timing_status_regs

// ### host_model.sv
// host-side model that reaches the rail registers one byte at a time
module host_model (
    // clock
    input wire logic core_clk,
    // register port toward the device
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port at time zero, nothing requested before reset releases
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // one-cycle write strobe, address and data held across the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // data is only trusted one full edge after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        // no read is taken at this edge, so the registered data cannot move here
        @(posedge core_clk);
        d = reg_rd_data;
    endtask : rd
endmodule : host_model

// ### tb.sv
// self-checking bench for the rail timing and status registers
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import buck_timing_status_pkg::*;
    // short tick keeps the 32 ms code within a few hundred cycles
    localparam int TICK = 4;
    logic core_clk, resetn, ref_pin, en_pin, pok_raw, hi_raw, pk_raw;
    wire logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    wire logic reg_wr_en, reg_rd_en, sw_pulse, turn_on, uv_flt, hi_flt, il_flt;
    seq_state_t seq_state;
    int err_total = 0;
    int tests_run = 0;
    logic [7:0] d;
    logic [15:0] k;

    buck_timing_status_regs #(.SEQ_TICK_CYCLES(TICK)) dut (.core_clk(core_clk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .main_clk_ref(ref_pin), .rail1_enable(en_pin), .rail2_power_good_raw(pok_raw),
        .rail2_high_output_raw(hi_raw), .rail2_peak_at_limit_raw(pk_raw),
        .rail1_switch_pulse(sw_pulse), .rail1_turn_on(turn_on),
        .rail1_seq_state(seq_state), .rail2_undervolt_fault(uv_flt),
        .rail2_high_output_fault(hi_flt), .rail2_current_limit_fault(il_flt));
    host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // edges from the pin change until the watched output reaches v; capped against hangs
    task automatic lat(input logic sel, input logic v, output logic [15:0] n);
        n = 16'h0000;
        do begin
            @(posedge core_clk);
            #1 n = n + 16'h0001;
        end while (((sel ? turn_on : sw_pulse) !== v) && n < 16'h0400);
    endtask : lat

    task automatic t_regs();
        chk(16'({uv_flt, hi_flt, il_flt}), 16'h0000, "faults after reset");
        host.rd(8'h47, d);
        chk(16'(d), 16'h00C0, "timing reset");
        host.rd(8'h60, d);
        chk(16'(d), 16'h000F, "status reset");
        host.wr(8'h47, 8'h2A);
        host.wr(8'h33, 8'hFF);
        host.rd(8'h47, d);
        chk(16'(d), 16'h002A, "timing write");
        host.rd(8'h33, d);
        chk(16'(d), 16'h0000, "unmapped read");
    endtask : t_regs

    task automatic t_phase();
        logic [7:0] cfg [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
        logic [15:0] exp [4] = '{16'h0003, 16'h0010, 16'h0003, 16'h0010};
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h47, cfg[i]);
            ref_pin <= cfg[i][6];
            repeat (20) @(posedge core_clk);
            ref_pin <= ~cfg[i][6];
            lat(1'b0, 1'b1, k);
            chk(k, exp[i], "switch pulse delay");
        end
    endtask : t_phase

    task automatic t_seq();
        logic [15:0] e;
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 16'h0003 : 16'((TICK << (i - 1)) + 3);
            host.wr(8'h47, {2'b00, 3'(i), 3'(i)});
            en_pin <= 1'b1;
            lat(1'b1, 1'b1, k);
            chk(k, e, "turn-on delay");
            @(posedge core_clk);
            en_pin <= 1'b0;
            lat(1'b1, 1'b0, k);
            chk(k, e, "turn-off delay");
        end
        // a glitch low mid-delay must restart the turn-on count from the new edge
        host.wr(8'h47, 8'h12);
        en_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(16'(seq_state), 16'(SEQ_COUNT), "delay running");
        en_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        en_pin <= 1'b1;
        lat(1'b1, 1'b1, k);
        chk(k, 16'(2 * TICK + 3), "restarted delay");
        chk(16'(seq_state), 16'(SEQ_IDLE), "delay finished");
    endtask : t_seq

    task automatic t_flags();
        host.wr(8'h60, 8'hF0);
        host.rd(8'h60, d);
        chk(16'(d), 16'h0000, "flag bits read-only");
        chk(16'(uv_flt), 16'h0001, "undervolt unmasked");
        hi_raw <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(16'(hi_flt), 16'h0001, "high output fault");
        hi_raw <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(16'(hi_flt), 16'h0001, "flag held unread");
        host.rd(8'h60, d);
        chk(16'(d), 16'h0040, "flag seen");
        repeat (3) @(posedge core_clk);
        host.rd(8'h60, d);
        chk(16'(d), 16'h0000, "flag cleared");
        host.wr(8'h60, 8'h04);
        hi_raw <= 1'b1;
        pok_raw <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(16'(hi_flt), 16'h0000, "masked fault");
        host.rd(8'h60, d);
        chk(16'(d), 16'h00C4, "live status masked");
        chk(16'(uv_flt), 16'h0000, "power good no fault");
        // peak held high, then counted over switching pulses on rising edges
        host.wr(8'h47, 8'h00);
        pk_raw <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            repeat (3) @(posedge core_clk);
            ref_pin <= 1'b1;
            repeat (3) @(posedge core_clk);
            ref_pin <= 1'b0;
            if (i == 14) begin
                repeat (6) @(posedge core_clk);
                chk(16'(il_flt), 16'h0000, "limit before 16");
            end
        end
        repeat (8) @(posedge core_clk);
        chk(16'(il_flt), 16'h0001, "limit at 16");
        host.rd(8'h60, d);
        chk(16'(d), 16'h00E4, "limit flag in status");
        // one pulse with peak low ends the run; the earlier read lets the flag drop
        pk_raw <= 1'b0;
        repeat (3) @(posedge core_clk);
        ref_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        ref_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(16'(il_flt), 16'h0000, "limit cleared after read");
    endtask : t_flags

    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // run takes under two thousand cycles; this bound is over ten times that
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        ref_pin = 1'b0;
        en_pin = 1'b0;
        pok_raw = 1'b0;
        hi_raw = 1'b0;
        pk_raw = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_phase();
        t_seq();
        t_flags();
        wrap_up();
    end
endmodule : tb
